/* File: rtl/host_port_defines.svh */
/*
  Constants of the host bus handover and asynchronous access port.
  Assumes a 125 MHz mclk; every cycle count is derived from a time in ns.
*/
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

`define HP_ADDR_W          32
`define HP_DATA_W          32
`define HP_CNT_W           4
`define HP_CNT_MAX         4'hF
`define HP_CNT_ZERO        4'h0
`define HP_CNT_ONE         4'h1

`define HP_CLK_NS          8
// least times round up to whole cycles
`define HP_CYC_CEIL(ns)    (((ns) + `HP_CLK_NS - 1) / `HP_CLK_NS)

`define HP_GRANT_RELEASE_NS 44
`define HP_READ_WAIT_NS     45
`define HP_WRITE_WAIT_NS    15

`define HP_GRANT_RELEASE_CYC 4'(`HP_CYC_CEIL(`HP_GRANT_RELEASE_NS))
`define HP_READ_WAIT_CYC     4'(`HP_CYC_CEIL(`HP_READ_WAIT_NS))
`define HP_WRITE_WAIT_CYC    4'(`HP_CYC_CEIL(`HP_WRITE_WAIT_NS))

// upper address line held high so the bus never looks like shared space
`define HP_NON_MMS_BIT     31

`define HP_CTRL_IDLE       4'hF
`define HP_HOST_SYNC_IDLE  2'h3

`endif

/* File: rtl/host_port_pkg.sv */
/*
  Types of the host port: state encodings of both ends.
  Assumes host_port_defines.svh for all numeric constants.
*/
package host_port_pkg;

  typedef enum logic [2:0] {
    DS_IDLE    = 3'h0,
    DS_HOLDOFF = 3'h1,
    DS_OPEN    = 3'h2,
    DS_RD_WAIT = 3'h3,
    DS_RD_DONE = 3'h4,
    DS_WR_WAIT = 3'h5,
    DS_WR_DONE = 3'h6
  } dev_state_e;

  typedef enum logic [2:0] {
    HS_IDLE   = 3'h0,
    HS_REQ    = 3'h1,
    HS_SETUP  = 3'h2,
    HS_STROBE = 3'h3,
    HS_HOLD   = 3'h4,
    HS_END    = 3'h5
  } host_state_e;

endpackage

/* File: rtl/host_port_if.sv */
/*
  Pins between the external host and the device port.
  Resolves the shared data bus, the open-drain ready line and the
  priority line from the drivers' enables; undriven ready and priority lines pull high, an undriven data bus reads zero.
*/
`timescale 1ns/100ps
`default_nettype none
`include "host_port_defines.svh"

interface host_port_if;
  logic                    host_bus_request_n;
  logic                    cs_n;
  logic                    rd_n;
  logic                    wr_n;
  logic [`HP_ADDR_W-1:0]   addr;
  logic                    host_bus_grant_n;
  logic                    multiproc_bus_request_n;
  logic                    ready_o;
  logic                    ready_oe;
  logic                    cpa_o;
  logic                    cpa_oe;
  logic [`HP_DATA_W-1:0]   dev_data;
  logic                    dev_data_oe;
  logic [`HP_DATA_W-1:0]   host_data;
  logic                    host_data_oe;
  wire                     host_wait_release;
  wire                     core_priority_access_n;
  wire  [`HP_DATA_W-1:0]   data_bus;

  assign host_wait_release      = ready_oe ? ready_o : 1'b1;
  assign core_priority_access_n = cpa_oe ? cpa_o : 1'b1;
  assign data_bus = dev_data_oe  ? dev_data :
                    host_data_oe ? host_data : '0;

  modport dev (
    input  host_bus_request_n, cs_n, rd_n, wr_n, addr, data_bus,
    output host_bus_grant_n, multiproc_bus_request_n, ready_o, ready_oe,
    output cpa_o, cpa_oe, dev_data, dev_data_oe
  );

  modport host (
    output host_bus_request_n, cs_n, rd_n, wr_n, addr, host_data, host_data_oe,
    input  host_bus_grant_n, host_wait_release, data_bus
  );
endinterface

`default_nettype wire

/* File: rtl/bit_sync.sv */
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes each bit is a level that is held over several mclk periods;
  multi-bit groups are only sampled once they have settled.
*/
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

`default_nettype wire

/* File: rtl/host_port_device.sv */
/*
  Device end of the host port: grants the shared bus to an external
  host, paces its asynchronous reads and writes with the ready line and
  carries them to internal memory or io processor registers.
  Assumes mem_ack answers each mem_req pulse; all pins are synchronised.
*/
// Functional notes
// - host requests, then waits for grant
// - request and grant stay low throughout
// - granted accesses reach memory at address
// - first address non-shared half cycle early
// - host holds upper address line high
// - late request is recognised next cycle
// - priority assertion synchronous, release free
// - ready low while selected before grant; driven low only from the edge that gives grant
// - ready released some time after grant
// - ready open-drain or active drive
// - read holds ready low minimum interval
// - read data valid before ready release
// - host raises read strobe after release
// - write holds ready low minimum interval
// - host holds write strobe past release
// - grant and bus request are registered
// - priority line driven low, never high
`timescale 1ns/100ps
`default_nettype none
`include "host_port_defines.svh"

module host_port_device (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // host pins
  host_port_if.dev                   pins,
  // configuration
  input  wire logic                  ready_active_drive,
  input  wire logic                  core_priority_req,
  // internal memory and io processor registers
  output logic                       mem_req,
  output logic                       mem_we,
  output logic [`HP_ADDR_W-1:0]      mem_addr,
  output logic [`HP_DATA_W-1:0]      mem_wdata,
  input  wire logic                  mem_ack,
  input  wire logic [`HP_DATA_W-1:0] mem_rdata
);

  //////////////////////////////////////////////////////////////////////////

  host_port_pkg::dev_state_e  state;
  host_port_pkg::dev_state_e  next_state;
  logic [`HP_CNT_W-1:0]       cnt;
  logic [`HP_CNT_W-1:0]       next_cnt;
  logic [3:0]                 ctrl_s;
  logic [`HP_ADDR_W+`HP_DATA_W-1:0] bus_s;
  logic                       acked;
  logic                       grant_n;
  logic                       mp_req_n;
  logic                       cpa_drive;
  logic [`HP_DATA_W-1:0]      rd_data;
  logic                       rd_data_oe;

  wire                        hbr_s;
  wire                        cs_s;
  wire                        rd_s;
  wire                        wr_s;
  wire [`HP_ADDR_W-1:0]       addr_s;
  wire [`HP_DATA_W-1:0]       data_s;
  wire                        selected;
  wire                        cnt_inc;
  wire                        read_start;
  wire                        write_issue;
  wire                        read_ready;
  wire                        ready_low;
  wire                        ready_active;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  bit_sync #(
    .WIDTH (4),
    .INIT  (`HP_CTRL_IDLE)
  ) u_ctrl_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({pins.host_bus_request_n, pins.cs_n, pins.rd_n, pins.wr_n}),
    .q     (ctrl_s)
  );

  // address and data are only used once the strobe is seen, by then settled
  bit_sync #(
    .WIDTH (`HP_ADDR_W + `HP_DATA_W),
    .INIT  ('0)
  ) u_bus_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({pins.addr, pins.data_bus}),
    .q     (bus_s)
  );

  assign hbr_s  = ctrl_s[3];
  assign cs_s   = ctrl_s[2];
  assign rd_s   = ctrl_s[1];
  assign wr_s   = ctrl_s[0];
  assign addr_s = bus_s[`HP_ADDR_W+`HP_DATA_W-1:`HP_DATA_W];
  assign data_s = bus_s[`HP_DATA_W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // decode

  // request seen on whichever edge it settles
  assign selected    = !hbr_s && !cs_s;
  assign cnt_inc     = (cnt != `HP_CNT_MAX);
  assign read_start  = (state == host_port_pkg::DS_OPEN) && !rd_s;
  assign write_issue = (state == host_port_pkg::DS_WR_WAIT) &&
                       (cnt == `HP_WRITE_WAIT_CYC - `HP_CNT_ONE);
  assign read_ready  = acked && (cnt >= `HP_READ_WAIT_CYC - `HP_CNT_ONE);

  //////////////////////////////////////////////////////////////////////////
  // access sequencer

  always_comb begin
    next_state = state;
    next_cnt   = cnt_inc ? cnt + `HP_CNT_ONE : cnt;
    case (state)
      host_port_pkg::DS_IDLE: begin
        next_cnt = `HP_CNT_ZERO;
        if (selected) begin
          next_state = host_port_pkg::DS_HOLDOFF;
        end
      end
      host_port_pkg::DS_HOLDOFF: begin
        if (cnt == `HP_GRANT_RELEASE_CYC - `HP_CNT_ONE) begin
          next_state = host_port_pkg::DS_OPEN;
        end
      end
      host_port_pkg::DS_OPEN: begin
        next_cnt = `HP_CNT_ZERO;
        if (!rd_s) begin
          next_state = host_port_pkg::DS_RD_WAIT;
        end else if (!wr_s) begin
          next_state = host_port_pkg::DS_WR_WAIT;
        end
      end
      host_port_pkg::DS_RD_WAIT: begin
        if (read_ready) begin
          next_state = host_port_pkg::DS_RD_DONE;
        end
      end
      host_port_pkg::DS_RD_DONE: begin
        if (rd_s) begin
          next_state = host_port_pkg::DS_OPEN;
        end
      end
      host_port_pkg::DS_WR_WAIT: begin
        if (acked) begin
          next_state = host_port_pkg::DS_WR_DONE;
        end
      end
      host_port_pkg::DS_WR_DONE: begin
        if (wr_s) begin
          next_state = host_port_pkg::DS_OPEN;
        end
      end
      default: begin
        next_state = host_port_pkg::DS_IDLE;
      end
    endcase
    // losing request or select ends tenure
    if (!selected) begin
      next_state = host_port_pkg::DS_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= host_port_pkg::DS_IDLE;
      cnt   <= `HP_CNT_ZERO;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // bus handover

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      grant_n  <= 1'b1;
      mp_req_n <= 1'b1;
    end else begin
      grant_n  <= (next_state == host_port_pkg::DS_IDLE);
      mp_req_n <= (next_state == host_port_pkg::DS_IDLE);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpa_drive <= 1'b0;
    end else begin
      cpa_drive <= core_priority_req;
    end
  end

  assign pins.host_bus_grant_n        = grant_n;
  assign pins.multiproc_bus_request_n = mp_req_n;
  assign pins.cpa_o                   = 1'b0;
  assign pins.cpa_oe                  = cpa_drive;

  //////////////////////////////////////////////////////////////////////////
  // internal access

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      acked     <= 1'b0;
    end else begin
      mem_req <= read_start || write_issue;
      if (read_start || write_issue) begin
        mem_we    <= write_issue;
        mem_addr  <= addr_s;
        mem_wdata <= data_s;
      end
      if (state == host_port_pkg::DS_OPEN) begin
        acked <= 1'b0;
      end else if (mem_ack) begin
        acked <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_data    <= '0;
      rd_data_oe <= 1'b0;
    end else begin
      if (state == host_port_pkg::DS_RD_WAIT && mem_ack && !mem_we) begin
        rd_data    <= mem_rdata;
        rd_data_oe <= 1'b1;
      end else if (next_state != host_port_pkg::DS_RD_WAIT &&
                   next_state != host_port_pkg::DS_RD_DONE) begin
        rd_data_oe <= 1'b0;
      end
    end
  end

  assign pins.dev_data    = rd_data;
  assign pins.dev_data_oe = rd_data_oe;

  //////////////////////////////////////////////////////////////////////////
  // ready line

  // held low from grant to release, and through read and write waits
  assign ready_low = (state == host_port_pkg::DS_HOLDOFF) ||
                     (state == host_port_pkg::DS_RD_WAIT) ||
                     (state == host_port_pkg::DS_WR_WAIT);

  assign ready_active = ready_active_drive && selected &&
                        (state != host_port_pkg::DS_IDLE);

  assign pins.ready_o  = !ready_low;
  assign pins.ready_oe = ready_low || ready_active;

endmodule

`default_nettype wire

/* File: rtl/host_port_host.sv */
/*
  Host end of the port: requests the bus, waits for grant, then runs one
  asynchronous read or write per command, paced by the ready line.
  Assumes command addresses lie outside multiprocessor memory space.
*/
`timescale 1ns/100ps
`default_nettype none
`include "host_port_defines.svh"

module host_port_host (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // device pins
  host_port_if.host                  pins,
  // commands
  input  wire logic                  cmd_valid,
  input  wire logic                  cmd_write,
  input  wire logic [`HP_ADDR_W-1:0] cmd_addr,
  input  wire logic [`HP_DATA_W-1:0] cmd_wdata,
  output logic                       cmd_ready,
  // read answers
  output logic                       rsp_valid,
  output logic [`HP_DATA_W-1:0]      rsp_rdata
);

  host_port_pkg::host_state_e state;
  logic [1:0]                 ctrl_s;
  logic [`HP_DATA_W-1:0]      data_s;
  logic                       hbr_n;
  logic                       cs_n;
  logic                       rd_n;
  logic                       wr_n;
  logic [`HP_ADDR_W-1:0]      addr;
  logic [`HP_DATA_W-1:0]      wdata;
  logic                       wdata_oe;
  logic                       is_write;
  logic                       seen_low;

  wire                        grant_s;
  wire                        ready_s;
  wire                        take;

  //////////////////////////////////////////////////////////////////////////

  bit_sync #(
    .WIDTH (2),
    .INIT  (`HP_HOST_SYNC_IDLE)
  ) u_ctrl_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({pins.host_bus_grant_n, pins.host_wait_release}),
    .q     (ctrl_s)
  );

  // same latency as ready, so data is settled when release is seen
  bit_sync #(
    .WIDTH (`HP_DATA_W),
    .INIT  ('0)
  ) u_data_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (pins.data_bus),
    .q     (data_s)
  );

  assign grant_s   = ctrl_s[1];
  assign ready_s   = ctrl_s[0];
  assign cmd_ready = (state == host_port_pkg::HS_IDLE);
  assign take      = cmd_valid && cmd_ready;

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state     <= host_port_pkg::HS_IDLE;
      hbr_n     <= 1'b1;
      cs_n      <= 1'b1;
      rd_n      <= 1'b1;
      wr_n      <= 1'b1;
      addr      <= '0;
      wdata     <= '0;
      wdata_oe  <= 1'b0;
      is_write  <= 1'b0;
      seen_low  <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        host_port_pkg::HS_IDLE: begin
          if (take) begin
            hbr_n    <= 1'b0;
            cs_n     <= 1'b0;
            is_write <= cmd_write;
            wdata    <= cmd_wdata;
            addr     <= '0;
            // keeps the bus out of shared space until the real address
            addr[`HP_NON_MMS_BIT] <= 1'b1;
            state    <= host_port_pkg::HS_REQ;
          end
        end
        host_port_pkg::HS_REQ: begin
          if (!grant_s) begin
            addr  <= cmd_addr;
            state <= host_port_pkg::HS_SETUP;
          end
        end
        // address stands a full cycle before the strobe falls
        host_port_pkg::HS_SETUP: begin
          if (ready_s) begin
            rd_n     <= is_write;
            wr_n     <= !is_write;
            wdata_oe <= is_write;
            seen_low <= 1'b0;
            state    <= host_port_pkg::HS_STROBE;
          end
        end
        host_port_pkg::HS_STROBE: begin
          if (!ready_s) begin
            seen_low <= 1'b1;
          end else if (seen_low) begin
            rsp_rdata <= data_s;
            state     <= host_port_pkg::HS_HOLD;
          end
        end
        host_port_pkg::HS_HOLD: begin
          rd_n      <= 1'b1;
          wr_n      <= 1'b1;
          rsp_valid <= !is_write;
          state     <= host_port_pkg::HS_END;
        end
        host_port_pkg::HS_END: begin
          wdata_oe <= 1'b0;
          hbr_n    <= 1'b1;
          cs_n     <= 1'b1;
          if (grant_s) begin
            state <= host_port_pkg::HS_IDLE;
          end
        end
        default: begin
          state <= host_port_pkg::HS_IDLE;
        end
      endcase
    end
  end

  assign pins.host_bus_request_n = hbr_n;
  assign pins.cs_n               = cs_n;
  assign pins.rd_n               = rd_n;
  assign pins.wr_n               = wr_n;
  assign pins.addr               = addr;
  assign pins.host_data          = wdata;
  assign pins.host_data_oe       = wdata_oe;

endmodule

`default_nettype wire

/* File: bench/host_port_chk.sv */
/*
  Pin checker for the host port, watching the interface between both ends.
  Assumes the bench feeds it the interface signals, all on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "host_port_defines.svh"

module host_port_chk (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // host pins
  input  wire logic                  host_bus_request_n,
  input  wire logic                  cs_n,
  input  wire logic                  rd_n,
  input  wire logic                  wr_n,
  input  wire logic [`HP_ADDR_W-1:0] addr,
  // device pins
  input  wire logic                  host_bus_grant_n,
  input  wire logic                  multiproc_bus_request_n,
  input  wire logic                  ready_oe,
  input  wire logic                  cpa_o,
  input  wire logic                  cpa_oe,
  input  wire logic                  dev_data_oe,
  input  wire logic                  host_wait_release
);
  logic selected;
  assign selected = !host_bus_request_n && !cs_n;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  chk_grant_after_sel:
  assert property ($rose(selected) |-> ##[2:4] !host_bus_grant_n)
    else $error("grant not given after request and select");
  chk_holdoff_low:
  assert property ($fell(host_bus_grant_n) |-> !host_wait_release)
    else $error("ready not low when grant given");
  chk_grant_release:
  assert property ($fell(host_bus_grant_n) |-> !host_wait_release [*6] ##[1:2] host_wait_release)
    else $error("ready released too early or never after grant");
  chk_drive_stops:
  assert property ($rose(host_bus_request_n) |-> ##[1:4] !ready_oe)
    else $error("ready still driven after request dropped");
  chk_read_wait:
  assert property ($fell(rd_n) |-> ##[1:3] !host_wait_release [*6])
    else $error("read wait shorter than minimum");
  chk_read_data:
  assert property ($rose(host_wait_release) && !rd_n |-> dev_data_oe && $past(dev_data_oe))
    else $error("read data not valid before ready release");
  chk_write_wait:
  assert property ($fell(wr_n) |-> ##[1:3] !host_wait_release [*2])
    else $error("write wait shorter than minimum");
  chk_request_mirror:
  assert property (multiproc_bus_request_n == host_bus_grant_n)
    else $error("bus request does not follow grant");
  chk_priority_low:
  assert property (cpa_oe |-> !cpa_o)
    else $error("priority line driven high");
  chk_strobe_granted:
  assert property ($fell(rd_n) || $fell(wr_n) |-> !host_bus_grant_n && selected
                   && $past(host_wait_release))
    else $error("strobe before grant and release");
  chk_grant_held:
  assert property (!rd_n || !wr_n |-> !host_bus_request_n && !host_bus_grant_n)
    else $error("request or grant lost during strobe");
  chk_strobe_rise:
  assert property ($rose(rd_n) || $rose(wr_n) |-> $past(host_wait_release))
    else $error("strobe raised before ready release");
  chk_addr_non_shared:
  assert property ($fell(rd_n) || $fell(wr_n) |-> addr[`HP_NON_MMS_BIT] && $stable(addr))
    else $error("address not settled outside shared space");
endmodule

`default_nettype wire

/* File: bench/host_bus_grant_async_port_tb_top.sv */
/*
  Testbench joining host and device ends, with a small memory behind the device.
  Assumes the bench drives every input at the falling edge of mclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "host_port_defines.svh"

module host_bus_grant_async_port_tb_top;
  logic                  mclk;
  logic                  rst_n;
  logic                  ready_active_drive;
  logic                  core_priority_req;
  logic                  mem_req;
  logic                  mem_we;
  logic [`HP_ADDR_W-1:0] mem_addr;
  logic [`HP_DATA_W-1:0] mem_wdata;
  logic                  mem_ack;
  logic [`HP_DATA_W-1:0] mem_rdata;
  logic                  cmd_valid;
  logic                  cmd_write;
  logic [`HP_ADDR_W-1:0] cmd_addr;
  logic [`HP_DATA_W-1:0] cmd_wdata;
  logic                  cmd_ready;
  logic                  rsp_valid;
  logic [`HP_DATA_W-1:0] rsp_rdata;
  logic [`HP_DATA_W-1:0] mem [0:15];
  logic [`HP_ADDR_W-1:0] last_addr;
  logic [`HP_DATA_W-1:0] last_wdata;
  logic                  pend;
  int                    lat;
  int                    mem_lat;
  int                    err_total;
  int                    n_checks;

  host_port_if host_port_if_inst ();

  host_port_device host_port_device_inst (
    .mclk(mclk), .rst_n(rst_n), .pins(host_port_if_inst.dev),
    .ready_active_drive(ready_active_drive), .core_priority_req(core_priority_req),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  host_port_host host_port_host_inst (
    .mclk(mclk), .rst_n(rst_n), .pins(host_port_if_inst.host),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata));

  host_port_chk host_port_chk_inst (
    .mclk(mclk), .rst_n(rst_n),
    .host_bus_request_n(host_port_if_inst.host_bus_request_n),
    .cs_n(host_port_if_inst.cs_n), .rd_n(host_port_if_inst.rd_n),
    .wr_n(host_port_if_inst.wr_n), .addr(host_port_if_inst.addr),
    .host_bus_grant_n(host_port_if_inst.host_bus_grant_n),
    .multiproc_bus_request_n(host_port_if_inst.multiproc_bus_request_n),
    .ready_oe(host_port_if_inst.ready_oe), .cpa_o(host_port_if_inst.cpa_o),
    .cpa_oe(host_port_if_inst.cpa_oe), .dev_data_oe(host_port_if_inst.dev_data_oe),
    .host_wait_release(host_port_if_inst.host_wait_release));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // memory answers after mem_lat falling edges, so prompt and slow acks both occur
  always @(negedge mclk) begin
    if (mem_req === 1'b1) begin
      pend = 1'b1;
      lat = mem_lat;
    end
    mem_ack <= pend && lat == 0;
    if (pend && lat == 0) begin
      pend = 1'b0;
      last_addr = mem_addr;
      last_wdata = mem_wdata;
      if (mem_we === 1'b1) mem[mem_addr[5:2]] = mem_wdata;
      mem_rdata <= mem[mem_addr[5:2]];
    end else if (pend) begin
      lat--;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
      err_total++;
    end
  endtask

  // one command through the host end; reads hand back the answered word
  task automatic access(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
    int i;
    for (i = 0; i < 300 && cmd_ready !== 1'b1; i++) @(negedge mclk);
    if (i == 300) err_total++;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
    for (i = 0; i < 300 && (wr ? cmd_ready !== 1'b1 : rsp_valid !== 1'b1); i++)
      @(negedge mclk);
    if (i == 300) err_total++;
    r = rsp_rdata;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    summarize();
  end

  initial begin
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] r;
    rst_n = 1'b0;
    ready_active_drive = 1'b1;
    core_priority_req = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 32'h8000_0000;
    cmd_wdata = 32'h0;
    pend = 1'b0;
    lat = 0;
    mem_lat = 0;
    err_total = 0;
    n_checks = 0;
    for (int i = 0; i < 16; i++) mem[i] = 32'h5A5A_0000 + 32'(i);
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    // both ready modes, prompt and slow memory, write then read back to back
    for (int m = 0; m < 2; m++) begin
      ready_active_drive = m[0];
      for (int k = 0; k < 3; k++) begin
        mem_lat = 2 * k;
        a = 32'h8000_0000 + 32'(4 * (3 * m + k));
        d = 32'hC0DE_0000 ^ a;
        access(1'b1, a, d, r);
        check(last_addr, a);
        check(last_wdata, d);
        access(1'b0, a, 32'h0, r);
        check(r, d);
        repeat (6) @(negedge mclk);
        check({31'h0, host_port_if_inst.ready_oe}, 32'h0);
        check({31'h0, host_port_if_inst.host_wait_release}, 32'h1);
      end
      $display("test mode %0d done", m);
    end
    // a location never written keeps its preset word
    access(1'b0, 32'h8000_003C, 32'h0, r);
    check(r, 32'h5A5A_000F);
    check(last_addr, 32'h8000_003C);
    $display("test unwritten read done");
    core_priority_req = 1'b1;
    repeat (2) @(negedge mclk);
    check({31'h0, host_port_if_inst.core_priority_access_n}, 32'h0);
    core_priority_req = 1'b0;
    repeat (2) @(negedge mclk);
    check({31'h0, host_port_if_inst.core_priority_access_n}, 32'h1);
    $display("test priority line done");
    summarize();
  end
endmodule

`default_nettype wire
